// file: bench/hub_port_config_monitor.sv
/* Checker of the hub port configuration registers.
 * Assumes the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module hub_port_config_monitor (
	input wire logic        clk_i, rst_i, ce_i, wr_i, rd_i,
	input wire logic        default_config_i, self_powered_i, remap_mode_o,
	input wire logic [7:0]  addr_i, wdata_i, rdata_o,
	input wire logic [7:0]  hub_current_o, peripheral_current_o,
	input wire logic [3:0]  port_enabled_o, port_fixed_o,
	input wire logic [2:0]  port_count_o,
	input wire logic [11:0] port_number_o
);
	logic [11:0] num;
	logic [2:0]  n;
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_comb begin
		n = 3'h0;
		num = 12'h000;
		for (int i = 0; i < 4; i++) begin
			n = n + {2'h0, port_enabled_o[i]};
			num[i*3 +: 3] = port_enabled_o[i] ? n : 3'h0;
		end
	end
	a_count_enabled: assert property (
		port_count_o == $countones(port_enabled_o)) else $error("count");
	a_number_order: assert property (
		port_number_o == num) else $error("numbering");
	a_periph_zero: assert property (
		peripheral_current_o == 8'h00) else $error("peripheral current");
	a_resv_zero: assert property (
		rd_i && ce_i && addr_i inside {8'h09, 8'h0a, 8'h0b}
		|=> (rdata_o & 8'he1) == 8'h00) else $error("reserved bits");
	a_current_write: assert property (
		ce_i && wr_i && addr_i == 8'h0c ##1 ce_i
		|=> hub_current_o == $past(wdata_i, 2)) else $error("current");
	a_remap_write: assert property (
		ce_i && wr_i && addr_i == 8'h08 ##1 ce_i
		|=> {7'h00, remap_mode_o} == ($past(wdata_i, 2) & 8'h08) >> 3)
		else $error("remap select");
	a_fixed_write: assert property (
		(ce_i && !default_config_i)[*6] ##0 (wr_i && addr_i == 8'h09)
		##1 ce_i |=> {3'h0, port_fixed_o, 1'b0} == ($past(wdata_i, 2)
		& 8'h1e)) else $error("fixed ports");
	a_sp_off: assert property (
		(ce_i && self_powered_i && !default_config_i)[*6] ##0 (wr_i
		&& addr_i == 8'h0a && wdata_i[4:1] == 4'hf && !remap_mode_o)
		##1 ce_i |=> port_enabled_o == 4'h0) else $error("sp port on");
	a_bp_off: assert property (
		(ce_i && !self_powered_i && !default_config_i)[*6] ##0 (wr_i
		&& addr_i == 8'h0b && wdata_i[4:1] == 4'hf && !remap_mode_o)
		##1 ce_i |=> port_enabled_o == 4'h0) else $error("bp port on");
endmodule : hub_port_config_monitor
bind hub_port_config_regs hub_port_config_monitor u_hub_port_config_monitor (
	.clk_i, .rst_i, .ce_i, .wr_i, .rd_i, .default_config_i, .self_powered_i,
	.remap_mode_o, .addr_i, .wdata_i, .rdata_o, .hub_current_o,
	.peripheral_current_o, .port_enabled_o, .port_fixed_o, .port_count_o,
	.port_number_o);
`default_nettype wire

// file: bench/test_hub_port_config_regs.sv
/* Self-checking bench of the hub port configuration registers.
 * Assumes the design, checker and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_hub_port_config_regs;
	import hub_port_config_pkg::*;
	logic clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, en = 0;
	logic default_config_i = 0, self_powered_i = 1, remap_mode_o;
	cfg_byte_t addr_i = 0, wdata_i = 0, rdata_o, hub_current_o, peripheral_current_o;
	port_vec_t fixed_port_strap_i = 0, port_off_strap_plus_i = 0;
	port_vec_t port_off_strap_minus_i = 0, port_enabled_o, port_fixed_o;
	port_num_t port_count_o;
	logic [11:0] port_number_o;
	logic [14:0] seen;
	cfg_byte_t ad[6] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h08, 8'h33};
	cfg_byte_t km[6] = '{8'h1e, 8'h1e, 8'h1e, 8'hff, 8'h09, 8'h00};
	cfg_byte_t r[6] = '{8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00};
	int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 53;
	hub_port_config_regs u_hub_port_config_regs (.clk_i, .rst_i, .ce_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .default_config_i,
		.self_powered_i, .fixed_port_strap_i, .port_off_strap_plus_i,
		.port_off_strap_minus_i, .port_enabled_o, .port_fixed_o, .port_count_o,
		.port_number_o, .hub_current_o, .peripheral_current_o, .remap_mode_o);
	upstream_host_model u_upstream_host_model (.clk_i, .enum_i(en),
		.port_count_i(port_count_o), .port_number_i(port_number_o), .seen_o(seen));
	// ---------------
	// Tasks and stimulus
	// ---------------
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 5000) begin error_cnt++; end_sim(); end
	task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input int k, input cfg_byte_t d);
		@(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, ad[k], d};
		@(posedge clk_i) wr_i <= 0;
		r[k] = d & km[k];
	endtask : wr
	task automatic rd(input int k);
		@(posedge clk_i) {rd_i, addr_i} <= {1'b1, ad[k]};
		@(posedge clk_i) rd_i <= 0;
		@(negedge clk_i) cmp(rdata_o, r[k]);
	endtask : rd
	task automatic chk;
		port_vec_t e;
		port_num_t n;
		logic [11:0] num;
		repeat (5) @(posedge clk_i);
		e = default_config_i ? ~(port_off_strap_plus_i | port_off_strap_minus_i)
			: r[4][3] ? 4'hf : ~(self_powered_i ? r[1][4:1] : r[2][4:1]);
		n = 3'h0;
		num = 12'h000;
		for (int i = 0; i < 4; i++) if (e[i]) begin
			n = n + 3'h1;
			num[i*3 +: 3] = n;
		end
		en <= 1;
		@(posedge clk_i) en <= 0;
		@(negedge clk_i) cmp(port_enabled_o, e);
		cmp(port_fixed_o, default_config_i ? fixed_port_strap_i : r[0][4:1]);
		cmp({port_count_o, port_number_o}, {n, num});
		cmp(seen, {n, num});
		cmp({hub_current_o, remap_mode_o}, {r[3], r[4][3]});
		cmp(peripheral_current_o, 15'h0000);
	endtask : chk
	task automatic end_sim;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		int k;
		cfg_byte_t d;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		for (k = 0; k < 6; k++) rd(k);
		wr(1, 8'hff);
		chk();
		@(posedge clk_i) self_powered_i <= 0;
		repeat (6) @(posedge clk_i);
		wr(2, 8'hff);
		chk();
		repeat (60) begin
			k = {$random(seed)} % 6;
			d = (k == 3) ? 8'({$random(seed)} % 51) : 8'($random(seed));
			wr(k, d);
			{fixed_port_strap_i, port_off_strap_plus_i, port_off_strap_minus_i}
				<= 12'($random(seed));
			self_powered_i <= 1'($random(seed));
			rd(k);
			chk();
		end
		d = r[3];
		@(posedge clk_i) ce_i <= 0;
		wr(3, 8'h11);
		r[3] = d;
		@(posedge clk_i) ce_i <= 1;
		rd(3);
		wr(4, 8'h00);
		default_config_i <= 1;
		repeat (12) begin
			@(posedge clk_i)
				{fixed_port_strap_i, port_off_strap_plus_i, port_off_strap_minus_i}
				<= 12'($random(seed));
			chk();
		end
		end_sim();
	end
endmodule : test_hub_port_config_regs
`default_nettype wire

// file: bench/upstream_host_model.sv
/* Upstream host view: latches the port count and numbering it enumerates.
 * Assumes the hub's registered result ports. */
`timescale 1ns/1ps
`default_nettype none
module upstream_host_model (
	input  wire logic        clk_i, enum_i,
	input  wire logic [2:0]  port_count_i,
	input  wire logic [11:0] port_number_i,
	output logic      [14:0] seen_o
);
	always_ff @(posedge clk_i) if (enum_i) seen_o <= {port_count_i, port_number_i};
endmodule : upstream_host_model
`default_nettype wire

// file: rtl/hub_port_config_defines.svh
/*
 * Offsets, field positions, reset values and figures of the hub port
 * configuration registers.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Overview of operation
// - Bits 4..1 of the fixed-port mask mark ports 4..1 non-removable when 1, other bits are reserved.
// - With the default configuration in use, the fixed-port straps replace the fixed-port mask.
// - Bits 4..1 of the self-powered port-off mask disable ports 4..1 when 1, other bits are reserved.
// - The bus-powered port-off mask has the same layout and meaning as the self-powered one.
// - With port remapping off, ports flagged in the active port-off mask are permanently disabled.
// - Any combination of disabled ports is accepted and the reported port count equals the enabled ports.
// - Enabled ports are renumbered contiguously and in order, skipping disabled ones.
// - With the default configuration in use, the port-off straps replace the port-off masks.
// - The self-powered upstream current is the 8-bit register value times 2 mA.
// - In a compound hub the embedded peripheral reports zero current of its own.
// - The remap select bit chooses standard numbering (0) or port mapping mode (1).
`ifndef HUB_PORT_CONFIG_DEFINES_SVH
`define HUB_PORT_CONFIG_DEFINES_SVH

`define ADDR_NONREMOVABLE_PORT_MASK     8'h09
`define ADDR_PORT_OFF_MASK_SELF_POWERED 8'h0a
`define ADDR_PORT_OFF_MASK_BUS_POWERED  8'h0b
`define ADDR_SELF_POWERED_CURRENT_DRAW  8'h0c
`define ADDR_HUB_MODE                   8'h08

`define PORT_FIELD_LSB   1
`define PORT_FIELD_MSB   4
`define PORT_FIELD_MASK  8'h1e
`define HUB_MODE_REMAP_BIT     3
`define HUB_MODE_COMPOUND_BIT  0

`define RESET_MASK      8'h00
`define RESET_CURRENT   8'h32
`define RESET_HUB_MODE  8'h00

`define CURRENT_STEP_MA    2
`define CURRENT_LIMIT_MA   100
`define PERIPHERAL_CURRENT_MA 8'h00

`endif

// file: rtl/hub_port_config_pkg.sv
/*
 * Types of the hub port configuration registers.
 * Assumes the defines header sits beside it.
 */
`include "hub_port_config_defines.svh"
package hub_port_config_pkg;
	typedef logic [7:0] cfg_byte_t;
	typedef logic [3:0] port_vec_t;
	typedef logic [2:0] port_num_t;
endpackage : hub_port_config_pkg

// file: rtl/hub_port_config_regs.sv
/*
 * Byte-wide port configuration registers of a four-port hub and the port
 * enable, count and renumbering logic that they steer.
 * Assumes a one-clock register port and strap pins from outside the domain.
 */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "hub_port_config_defines.svh"

module hub_port_config_regs
	import hub_port_config_pkg::*;
(
	// Clock, reset and enable
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	input  wire logic  ce_i,
	// Register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Configuration source and power mode
	input  wire logic       default_config_i,
	input  wire logic       self_powered_i,
	// Straps
	input  wire logic [3:0] fixed_port_strap_i,
	input  wire logic [3:0] port_off_strap_plus_i,
	input  wire logic [3:0] port_off_strap_minus_i,
	// Results toward the hub core
	output logic      [3:0] port_enabled_o,
	output logic      [3:0] port_fixed_o,
	output logic      [2:0] port_count_o,
	output logic     [11:0] port_number_o,
	output logic      [7:0] hub_current_o,
	output logic      [7:0] peripheral_current_o,
	output logic            remap_mode_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	cfg_byte_t nonremovable_port_mask;
	cfg_byte_t port_off_mask_self_powered;
	cfg_byte_t port_off_mask_bus_powered;
	cfg_byte_t self_powered_current_draw;
	cfg_byte_t hub_mode;
	logic [11:0] strap_meta;
	logic [11:0] strap_sync;
	logic [1:0]  mode_meta;
	logic [1:0]  mode_sync;

	wire cfg_byte_t port_field = `PORT_FIELD_MASK;
	wire logic sel_nr = addr_i == `ADDR_NONREMOVABLE_PORT_MASK;
	wire logic sel_sp = addr_i == `ADDR_PORT_OFF_MASK_SELF_POWERED;
	wire logic sel_bp = addr_i == `ADDR_PORT_OFF_MASK_BUS_POWERED;
	wire logic sel_cur = addr_i == `ADDR_SELF_POWERED_CURRENT_DRAW;
	wire logic sel_mode = addr_i == `ADDR_HUB_MODE;
	wire cfg_byte_t masked_wdata = wdata_i & port_field;
	wire cfg_byte_t mode_wmask = 8'h09;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nonremovable_port_mask <= `RESET_MASK;
			port_off_mask_self_powered <= `RESET_MASK;
			port_off_mask_bus_powered <= `RESET_MASK;
			self_powered_current_draw <= `RESET_CURRENT;
			hub_mode <= `RESET_HUB_MODE;
		end else if (ce_i && wr_i) begin
			if (sel_nr) nonremovable_port_mask <= masked_wdata;
			if (sel_sp) port_off_mask_self_powered <= masked_wdata;
			if (sel_bp) port_off_mask_bus_powered <= masked_wdata;
			if (sel_cur) self_powered_current_draw <= wdata_i;
			if (sel_mode) hub_mode <= wdata_i & mode_wmask;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	wire cfg_byte_t read_mux =
		sel_nr   ? nonremovable_port_mask :
		sel_sp   ? port_off_mask_self_powered :
		sel_bp   ? port_off_mask_bus_powered :
		sel_cur  ? self_powered_current_draw :
		sel_mode ? hub_mode : 8'h00;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) rdata_o <= 8'h00;
		else if (ce_i) rdata_o <= rd_i ? read_mux : 8'h00;
	end

	// ----------------------------------------------------------------
	// Strap synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_meta <= 12'h000;
			strap_sync <= 12'h000;
			mode_meta <= 2'h0;
			mode_sync <= 2'h0;
		end else if (ce_i) begin
			strap_meta <= {fixed_port_strap_i, port_off_strap_plus_i,
				port_off_strap_minus_i};
			strap_sync <= strap_meta;
			mode_meta <= {default_config_i, self_powered_i};
			mode_sync <= mode_meta;
		end
	end

	// ----------------------------------------------------------------
	// Port selection and renumbering
	// ----------------------------------------------------------------
	wire logic use_default = mode_sync[1];
	wire logic self_pwr = mode_sync[0];
	wire logic remap = hub_mode[`HUB_MODE_REMAP_BIT];
	wire port_vec_t reg_off = self_pwr ?
		port_off_mask_self_powered[`PORT_FIELD_MSB:`PORT_FIELD_LSB] :
		port_off_mask_bus_powered[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
	wire port_vec_t strap_off = strap_sync[7:4] | strap_sync[3:0];
	wire port_vec_t off_src = use_default ? strap_off : reg_off;
	wire port_vec_t off_eff = remap ? 4'h0 : off_src;
	wire port_vec_t next_enabled = ~off_eff;
	wire port_vec_t next_fixed = use_default ? strap_sync[11:8] :
		nonremovable_port_mask[`PORT_FIELD_MSB:`PORT_FIELD_LSB];

	port_num_t num [4];
	assign num[0] = next_enabled[0] ? 3'd1 : 3'd0;
	assign num[1] = next_enabled[1] ?
		3'(next_enabled[0]) + 3'd1 : 3'd0;
	assign num[2] = next_enabled[2] ?
		3'(next_enabled[0]) + 3'(next_enabled[1]) + 3'd1 : 3'd0;
	assign num[3] = next_enabled[3] ? 3'(next_enabled[0]) +
		3'(next_enabled[1]) + 3'(next_enabled[2]) + 3'd1 : 3'd0;
	wire port_num_t next_count = 3'(next_enabled[0]) + 3'(next_enabled[1])
		+ 3'(next_enabled[2]) + 3'(next_enabled[3]);
	wire logic compound = hub_mode[`HUB_MODE_COMPOUND_BIT] |
		(use_default & (|strap_sync[11:8]));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_enabled_o <= 4'h0;
			port_fixed_o <= 4'h0;
			port_count_o <= 3'h0;
			port_number_o <= 12'h000;
			hub_current_o <= 8'h00;
			peripheral_current_o <= 8'h00;
			remap_mode_o <= 1'b0;
		end else if (ce_i) begin
			port_enabled_o <= next_enabled;
			port_fixed_o <= next_fixed;
			port_count_o <= next_count;
			port_number_o <= {num[3], num[2], num[1], num[0]};
			hub_current_o <= self_powered_current_draw;
			peripheral_current_o <= compound ?
				`PERIPHERAL_CURRENT_MA : 8'h00;
			remap_mode_o <= remap;
		end
	end

endmodule : hub_port_config_regs
`default_nettype wire
